// file: core/dtp_regs.svh
// Register addresses, field positions, reset values and prescaler counts for the dual timer
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

// Register addresses on the special-function port
`define DTP_ADDR_RUN_FLAGS   8'h88
`define DTP_ADDR_MODE_CONFIG 8'h89
`define DTP_ADDR_FIRST_LOW   8'h8a
`define DTP_ADDR_SECOND_LOW  8'h8b
`define DTP_ADDR_FIRST_HIGH  8'h8c
`define DTP_ADDR_SECOND_HIGH 8'h8d
`define DTP_ADDR_CLOCK_SEL   8'h8e

// Clock select fields
`define DTP_CS_THIRD_HIGH    6
`define DTP_CS_THIRD_LOW     5
`define DTP_CS_SECOND        4
`define DTP_CS_FIRST         3
`define DTP_CS_DIV_HI        1
`define DTP_CS_DIV_LO        0
`define DTP_CS_WRITE_MASK    8'h7b

// Run and flag fields
`define DTP_RF_SECOND_FLAG   7
`define DTP_RF_SECOND_RUN    6
`define DTP_RF_FIRST_FLAG    5
`define DTP_RF_FIRST_RUN     4

// Mode config fields
`define DTP_MC_SECOND_GATE   7
`define DTP_MC_SECOND_CNT    6
`define DTP_MC_FIRST_GATE    3
`define DTP_MC_FIRST_CNT     2

// Reset values
`define DTP_RST_CLOCK_SEL    8'h00
`define DTP_RST_MODE_CONFIG  8'h00
`define DTP_RST_BYTE         8'h00

// Prescaler division counts
`define DTP_DIV_BY_12        6'd12
`define DTP_DIV_BY_4         6'd4
`define DTP_DIV_BY_48        6'd48
`define DTP_DIV_EXT_BY_8     6'd8

`endif

// file: core/dtp_pkg.sv
// Types shared by the dual timer modules
package dtp_pkg;

	// One-hot decode of a two-bit timer mode field
	typedef enum logic [3:0] {
		DTP_MODE_13BIT  = 4'b0001,
		DTP_MODE_16BIT  = 4'b0010,
		DTP_MODE_RELOAD = 4'b0100,
		DTP_MODE_SPLIT  = 4'b1000
	} dtp_mode_e;

	// Prescaler divide choice
	typedef logic [1:0] dtp_div_t;

endpackage : dtp_pkg

// file: core/dtp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dtp_sync #(
	parameter int W = 5
) (
	input  wire logic         clk_sys_i,   // System clock
	input  wire logic         reset_n_i,   // Async reset, active low
	input  wire logic         ce_i,        // Clock enable
	input  wire logic [W-1:0] pin_i,       // Raw pin levels
	output logic      [W-1:0] level_o      // Filtered levels
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_nxt;

	// A bit only changes once stages two and three agree, rejecting one-cycle glitches
	assign level_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_o);

	// Stage one feeds only stage two
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			level_o <= '0;
		end else if (ce_i) begin
			s1_r    <= pin_i;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_o <= level_nxt;
		end
	end

endmodule : dtp_sync

// file: core/dtp_prescaler.sv
// Shared timer prescaler: system clock by 12, 4, 48 or external clock by 8
`timescale 1ns/10ps
`include "dtp_regs.svh"
module dtp_prescaler (
	input  wire logic            clk_sys_i,   // System clock
	input  wire logic            reset_n_i,   // Async reset, active low
	input  wire logic            ce_i,        // Clock enable
	input  wire dtp_pkg::dtp_div_t div_sel_i, // Divide choice
	input  wire logic            ext_rise_i,  // Synchronised external clock rising edge
	output logic                 tick_o       // One-cycle prescaled tick
);

	logic [5:0] cnt_r;
	logic [5:0] limit;
	logic       step;
	logic       wrap;

	// Division count and count condition per choice
	assign limit = (div_sel_i == 2'b00) ? `DTP_DIV_BY_12 :
	               (div_sel_i == 2'b01) ? `DTP_DIV_BY_4  :
	               (div_sel_i == 2'b10) ? `DTP_DIV_BY_48 : `DTP_DIV_EXT_BY_8;
	assign step  = (div_sel_i == 2'b11) ? ext_rise_i : 1'b1;
	// Counting past the limit after a choice change wraps at once, no long stall
	assign wrap  = step && (cnt_r >= limit - 6'd1);

	// Divider counter and tick
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r  <= 6'h00;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			cnt_r  <= wrap ? 6'h00 : (step ? cnt_r + 6'd1 : cnt_r);
			tick_o <= wrap;
		end
	end

	a_div4_spacing: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(ce_i && tick_o && div_sel_i == 2'b01 && cnt_r == 6'h00) ##1 (ce_i && div_sel_i == 2'b01)[*3]
		|=> tick_o)
		else $error("divide-by-4 tick spacing wrong");

endmodule : dtp_prescaler

// file: core/dtp_timer.sv
// Dual counter/timer with shared prescaler and clock-select register
//
// How it works
// - Clock-select bits seven and two read zero and ignore writes.
// - Prescaler: /12, /4, /48 of system clock, or external clock /8.
// - Second timer clock bit: 0 prescaled, 1 system; ignored when counting pins.
// - First timer clock bit: 0 prescaled, 1 system; ignored when counting pins.
// - Third timer split high byte: system clock if select set, else its own choice.
// - Third timer low clock: system clock if select set, else its own choice.
// - Each general timer holds sixteen bits as separate low and high bytes.
// - Thirteen-bit mode: high byte upper eight, low byte bits four..zero.
// - Thirteen-bit wrap from 1fff to 0 sets the overflow flag.
// - Counter select set: count falling edges on the count pin.
// - Count only if run set and gate clear or gate input active.
// - Setting run keeps the count; software preloads it.
// - Second timer mirrors the first with its own bits and inputs.
// - Sixteen-bit mode counts all bits, gated like thirteen-bit mode.
// - Reload mode: low byte wraps to high byte value, flag set.
// - Split mode: first low byte is a full timer with first controls.
// - Split mode: first high byte times, runs on second run bit, sets second flag.
// - While split, second timer never counts pins nor sets its flag; pulse stays.
// - Second timer in mode three stops; while split it runs in modes 0-2.
// - Mode field: 00 13-bit, 01 16-bit, 10 reload, 11 split or inactive.
// - Overflow flag set by hardware, cleared by software or interrupt vectoring.
`timescale 1ns/10ps
`include "dtp_regs.svh"
module dtp_timer (
	input  wire logic       clk_sys_i,             // System clock, 100 MHz
	input  wire logic       reset_n_i,             // Async reset, active low
	input  wire logic       ce_i,                  // Clock enable, freezes all state
	input  wire logic [7:0] sfr_addr_i,            // Register address
	input  wire logic       sfr_wr_i,              // Register write strobe
	input  wire logic       sfr_rd_i,              // Register read strobe
	input  wire logic [7:0] sfr_wdata_i,           // Register write data
	output logic      [7:0] sfr_rdata_o,           // Register read data, one cycle after strobe
	input  wire logic       first_count_pin_i,     // First timer count pin
	input  wire logic       second_count_pin_i,    // Second timer count pin
	input  wire logic       first_gate_input_i,    // First gate pin
	input  wire logic       second_gate_input_i,   // Second gate pin
	input  wire logic       ext_clock_pin_i,       // External clock for the prescaler
	input  wire logic       first_gate_polarity_i, // 1: first gate active high
	input  wire logic       second_gate_polarity_i,// 1: second gate active high
	input  wire logic       first_vector_ack_i,    // Processor vectors to first timer interrupt
	input  wire logic       second_vector_ack_i,   // Processor vectors to second timer interrupt
	input  wire logic       first_interrupt_enable_i,  // First timer interrupt enable
	input  wire logic       second_interrupt_enable_i, // Second timer interrupt enable
	input  wire logic       third_ext_tick_i,      // Tick of third timer's own external choice
	output logic            first_irq_o,           // First timer interrupt request
	output logic            second_irq_o,          // Second timer interrupt request
	output logic            first_overflow_flag_o, // First overflow flag
	output logic            second_overflow_flag_o,// Second overflow flag
	output logic            second_ovf_pulse_o,    // Second timer overflow pulse for baud and ADC
	output logic            third_low_tick_o,      // Third timer low byte count tick
	output logic            third_high_tick_o      // Third timer high byte count tick
);

	logic [7:0] clock_sel_r;
	logic [7:0] mode_cfg_r;
	logic       first_run_r;
	logic       second_run_r;
	logic       first_flag_r;
	logic       second_flag_r;
	logic [7:0] first_low_r;
	logic [7:0] first_high_r;
	logic [7:0] second_low_r;
	logic [7:0] second_high_r;
	logic [4:0] lvl;
	logic [4:0] prev_r;
	logic       presc_tick;

	// Count one step of a timer pair; returns {overflow, high, low}
	function automatic logic [16:0] step_pair(input logic [1:0] m, input logic [7:0] hi,
	                                          input logic [7:0] lo, input logic inc);
		dtp_pkg::dtp_mode_e me;
		logic [12:0] c13;
		logic [15:0] c16;
		me  = dtp_pkg::dtp_mode_e'(4'b0001 << m);
		c13 = {hi, lo[4:0]} + 13'd1;
		c16 = {hi, lo} + 16'd1;
		step_pair = {1'b0, hi, lo};
		if (inc) begin
			unique case (me)
				dtp_pkg::DTP_MODE_13BIT:  step_pair = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
				dtp_pkg::DTP_MODE_16BIT:  step_pair = {&{hi, lo}, c16};
				dtp_pkg::DTP_MODE_RELOAD: step_pair = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'd1};
				dtp_pkg::DTP_MODE_SPLIT:  step_pair = {&lo, hi, lo + 8'd1};
			endcase
		end
	endfunction : step_pair

	// Timer clock: pin edges when counting, else system clock or prescaled tick
	function automatic logic pick_tick(input logic cnt_sel, input logic sys_sel,
	                                   input logic fall, input logic presc);
		pick_tick = cnt_sel ? fall : (sys_sel ? 1'b1 : presc);
	endfunction : pick_tick

	// Gate passes when unused or when the gate pin matches its active polarity
	function automatic logic gate_ok(input logic gate, input logic pin, input logic pol);
		gate_ok = !gate || (pin == pol);
	endfunction : gate_ok

	// Pin synchronisers; order is count0, count1, first_gate_input_i, second_gate_input_i, external clock
	dtp_sync #(.W(5)) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.pin_i     ({ext_clock_pin_i, second_gate_input_i, first_gate_input_i,
		              second_count_pin_i, first_count_pin_i}),
		.level_o   (lvl)
	);

	// Shared prescaler
	dtp_prescaler u_presc (
		.clk_sys_i  (clk_sys_i),
		.reset_n_i  (reset_n_i),
		.ce_i       (ce_i),
		.div_sel_i  (clock_sel_r[`DTP_CS_DIV_HI:`DTP_CS_DIV_LO]),
		.ext_rise_i (lvl[4] && !prev_r[4]),
		.tick_o     (presc_tick)
	);

	// Register decode
	wire hit_cs  = sfr_addr_i == `DTP_ADDR_CLOCK_SEL;
	wire hit_rf  = sfr_addr_i == `DTP_ADDR_RUN_FLAGS;
	wire hit_mc  = sfr_addr_i == `DTP_ADDR_MODE_CONFIG;
	wire hit_l0  = sfr_addr_i == `DTP_ADDR_FIRST_LOW;
	wire hit_h0  = sfr_addr_i == `DTP_ADDR_FIRST_HIGH;
	wire hit_l1  = sfr_addr_i == `DTP_ADDR_SECOND_LOW;
	wire hit_h1  = sfr_addr_i == `DTP_ADDR_SECOND_HIGH;
	wire wr_rf   = sfr_wr_i && hit_rf;
	wire wr_l0   = sfr_wr_i && hit_l0;
	wire wr_h0   = sfr_wr_i && hit_h0;
	wire wr_l1   = sfr_wr_i && hit_l1;
	wire wr_h1   = sfr_wr_i && hit_h1;

	// Mode fields
	wire [1:0] mode0 = mode_cfg_r[1:0];
	wire [1:0] mode1 = mode_cfg_r[5:4];
	wire       cnt0  = mode_cfg_r[`DTP_MC_FIRST_CNT];
	wire       cnt1  = mode_cfg_r[`DTP_MC_SECOND_CNT];
	wire       first_gate_bit = mode_cfg_r[`DTP_MC_FIRST_GATE];
	wire       second_gate_bit = mode_cfg_r[`DTP_MC_SECOND_GATE];
	wire       split = mode0 == 2'b11;

	// Falling edges from consecutive synchronised samples
	wire fall0 = prev_r[0] && !lvl[0];
	wire fall1 = prev_r[1] && !lvl[1];

	// Clock selection per counter
	wire tick0  = pick_tick(cnt0, clock_sel_r[`DTP_CS_FIRST], fall0, presc_tick);
	wire tick0h = clock_sel_r[`DTP_CS_FIRST] ? 1'b1 : presc_tick;
	// While split the second timer loses its pin clock
	wire tick1  = pick_tick(cnt1 && !split, clock_sel_r[`DTP_CS_SECOND], fall1, presc_tick);

	// Enables; split mode hands second timer run control to its mode field
	wire en0  = first_run_r && gate_ok(first_gate_bit, lvl[2], first_gate_polarity_i);
	wire en1n = second_run_r && gate_ok(second_gate_bit, lvl[3], second_gate_polarity_i);
	wire en1  = (mode1 != 2'b11) && (split || en1n);
	wire inc0  = en0 && tick0;
	wire inc0h = split && second_run_r && tick0h;
	wire inc1  = en1 && tick1;

	// Next counter values
	wire [16:0] s0 = step_pair(mode0, first_high_r, first_low_r, inc0);
	wire [16:0] s1 = step_pair(mode1, second_high_r, second_low_r, inc1);
	wire        th0_wrap = inc0h && (&first_high_r);
	wire        ovf0 = s0[16];
	wire        ovf1 = s1[16];
	wire        set_tf1 = split ? th0_wrap : ovf1;

	wire [7:0] first_low_nxt   = wr_l0 ? sfr_wdata_i : s0[7:0];
	wire [7:0] first_high_nxt  = wr_h0 ? sfr_wdata_i : (inc0h ? first_high_r + 8'd1 : s0[15:8]);
	wire [7:0] second_low_nxt  = wr_l1 ? sfr_wdata_i : s1[7:0];
	wire [7:0] second_high_nxt = wr_h1 ? sfr_wdata_i : s1[15:8];

	// Flags: a hardware set beats a software write or a vector clear in the same cycle
	wire first_flag_nxt  = ovf0 || (wr_rf ? sfr_wdata_i[`DTP_RF_FIRST_FLAG] :
	                                (!first_vector_ack_i && first_flag_r));
	wire second_flag_nxt = set_tf1 || (wr_rf ? sfr_wdata_i[`DTP_RF_SECOND_FLAG] :
	                                   (!second_vector_ack_i && second_flag_r));

	// Read mux; unmapped addresses read zero
	wire [7:0] rdata_nxt =
		hit_cs ? clock_sel_r :
		hit_rf ? {second_flag_r, second_run_r, first_flag_r, first_run_r, 4'h0} :
		hit_mc ? mode_cfg_r :
		hit_l0 ? first_low_r :
		hit_h0 ? first_high_r :
		hit_l1 ? second_low_r :
		hit_h1 ? second_high_r : 8'h00;

	// Configuration registers; reserved clock-select bits never store
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clock_sel_r  <= `DTP_RST_CLOCK_SEL;
			mode_cfg_r   <= `DTP_RST_MODE_CONFIG;
			first_run_r  <= 1'b0;
			second_run_r <= 1'b0;
		end else if (ce_i) begin
			if (sfr_wr_i && hit_cs) clock_sel_r <= sfr_wdata_i & `DTP_CS_WRITE_MASK;
			if (sfr_wr_i && hit_mc) mode_cfg_r <= sfr_wdata_i;
			if (wr_rf) begin
				first_run_r  <= sfr_wdata_i[`DTP_RF_FIRST_RUN];
				second_run_r <= sfr_wdata_i[`DTP_RF_SECOND_RUN];
			end
		end
	end

	// Counters, flags, pulse, edge history and read data
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			first_low_r        <= `DTP_RST_BYTE;
			first_high_r       <= `DTP_RST_BYTE;
			second_low_r       <= `DTP_RST_BYTE;
			second_high_r      <= `DTP_RST_BYTE;
			first_flag_r       <= 1'b0;
			second_flag_r      <= 1'b0;
			second_ovf_pulse_o <= 1'b0;
			prev_r             <= 5'h00;
			sfr_rdata_o        <= 8'h00;
		end else if (ce_i) begin
			first_low_r        <= first_low_nxt;
			first_high_r       <= first_high_nxt;
			second_low_r       <= second_low_nxt;
			second_high_r      <= second_high_nxt;
			first_flag_r       <= first_flag_nxt;
			second_flag_r      <= second_flag_nxt;
			second_ovf_pulse_o <= ovf1;
			prev_r             <= lvl;
			if (sfr_rd_i) sfr_rdata_o <= rdata_nxt;
		end
	end

	// Flag outputs and interrupt requests
	assign first_overflow_flag_o  = first_flag_r;
	assign second_overflow_flag_o = second_flag_r;
	assign first_irq_o            = first_flag_r && first_interrupt_enable_i;
	assign second_irq_o           = second_flag_r && second_interrupt_enable_i;

	// Third timer clock choice; high select only matters in its split mode
	assign third_low_tick_o  = clock_sel_r[`DTP_CS_THIRD_LOW] ? 1'b1 : third_ext_tick_i;
	assign third_high_tick_o = clock_sel_r[`DTP_CS_THIRD_HIGH] ? 1'b1 : third_ext_tick_i;

	a_cs_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && sfr_wr_i && hit_cs |=> clock_sel_r[7] == 1'b0 && clock_sel_r[2] == 1'b0 &&
		clock_sel_r[6:3] == $past(sfr_wdata_i[6:3]))
		else $error("clock select reserved bits not zero");

	a_wrap_13bit_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'b00 && inc0 && first_high_r == 8'hff && first_low_r[4:0] == 5'h1f
		&& !wr_l0 && !wr_h0 |=> first_flag_r && first_high_r == 8'h00 && first_low_r[4:0] == 5'h00)
		else $error("13-bit wrap did not flag or clear");

	a_wrap_16bit_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode1 == 2'b01 && inc1 && !split && {second_high_r, second_low_r} == 16'hffff
		&& !wr_l1 && !wr_h1 |=> second_flag_r && {second_high_r, second_low_r} == 16'h0000)
		else $error("16-bit wrap did not flag");

	a_reload_on_wrap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'b10 && inc0 && first_low_r == 8'hff && !wr_l0 && !wr_h0
		|=> first_low_r == $past(first_high_r) && first_high_r == $past(first_high_r) && first_flag_r)
		else $error("reload mode did not reload");

	a_hold_when_off: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && !en0 && !split && !wr_l0 && !wr_h0 |=> $stable(first_low_r) && $stable(first_high_r))
		else $error("disabled timer changed");

	a_run_keeps_count: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && wr_rf && sfr_wdata_i[`DTP_RF_FIRST_RUN] && !first_run_r && !split && !wr_l0 && !wr_h0
		|=> first_low_r == $past(first_low_r) && first_high_r == $past(first_high_r))
		else $error("setting run altered count");

	a_pin_edge_count: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'b01 && cnt0 && en0 && fall0 && !wr_l0 && !wr_h0
		&& {first_high_r, first_low_r} != 16'hffff
		|=> {first_high_r, first_low_r} == $past({first_high_r, first_low_r}) + 16'd1)
		else $error("falling pin edge not counted");

	a_mode3_stops: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode1 == 2'b11 && !wr_l1 && !wr_h1 |=> $stable({second_high_r, second_low_r}))
		else $error("second timer counted in mode 3");

	a_split_no_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && split && !th0_wrap && !wr_rf && !second_flag_r |=> !second_flag_r)
		else $error("second flag set by second timer while split");

	a_vector_clears: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && first_vector_ack_i && !ovf0 && !wr_rf |=> !first_flag_r)
		else $error("vector did not clear first flag");

	a_presc_step_first: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode0 == 2'b01 && !cnt0 && !clock_sel_r[`DTP_CS_FIRST] && en0 && presc_tick
		&& !wr_l0 && !wr_h0 && {first_high_r, first_low_r} != 16'hffff
		|=> {first_high_r, first_low_r} == $past({first_high_r, first_low_r}) + 16'd1)
		else $error("first timer missed a prescaled tick");

	a_presc_step_second: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && mode1 == 2'b01 && !cnt1 && !split && !clock_sel_r[`DTP_CS_SECOND] && en1 && presc_tick
		&& !wr_l1 && !wr_h1 && {second_high_r, second_low_r} != 16'hffff
		|=> {second_high_r, second_low_r} == $past({second_high_r, second_low_r}) + 16'd1)
		else $error("second timer missed a prescaled tick");

endmodule : dtp_timer

// file: test/dtp_pin_model.sv
// Model of the external count pins: one clean falling edge per request
`timescale 1ns/10ps
module dtp_pin_model #(
	parameter int HOLD = 3
) (
	input  wire logic       clk_sys_i,   // System clock
	input  wire logic [1:0] fire_i,      // Request one low pulse per pin
	output logic      [1:0] count_pin_o  // Count pins, idle high by pull-up
);
	logic [4:0] cnt_r [2];

	// Each level stands HOLD clocks; HOLD below 2 would break sampling
	initial begin
		count_pin_o = 2'b11;
		cnt_r[0] = 5'h00;
		cnt_r[1] = 5'h00;
	end
	always @(posedge clk_sys_i) begin
		for (int i = 0; i < 2; i++) begin
			if (fire_i[i] && cnt_r[i] == 5'h00) cnt_r[i] <= 5'(2 * HOLD);
			else if (cnt_r[i] != 5'h00) cnt_r[i] <= cnt_r[i] - 5'h01;
			count_pin_o[i] <= !(cnt_r[i] > 5'(HOLD));
		end
	end
endmodule : dtp_pin_model

// file: test/dtp_timer_tb.sv
// Self-checking bench for the dual timer and its clock-select register
`timescale 1ns/10ps
module dtp_timer_tb;
	logic       clk_sys_i, reset_n_i, wr, rd, rd_d, tick, ien;
	logic [7:0] addr, wdata, rdata, m, d;
	logic [1:0] fire, cpin, ack, gate, flg, irq, pol;
	logic       tlo, thi, pulse;
	int         err_count, checks, cyc, e, pulses, p;
	logic [7:0] exp_q[$], msk_q[$];
	logic [3:0] nib [5] = '{4'h5, 4'h6, 4'h4, 4'hd, 4'h7};
	logic [7:0] lo [5] = '{8'hfe, 8'hff, 8'h1f, 8'h10, 8'hff};
	logic [7:0] hi [5] = '{8'hff, 8'h80, 8'hff, 8'h20, 8'h05};
	logic [7:0] elo [5] = '{8'h00, 8'h80, 8'h00, 8'h10, 8'h00};
	logic [7:0] ehi [5] = '{8'h00, 8'h80, 8'h00, 8'h20, 8'h05};
	int         n [5] = '{2, 1, 1, 1, 1};
	int         dv [4] = '{12, 4, 48, 4};

	dtp_timer u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
		.first_count_pin_i(cpin[0]), .second_count_pin_i(cpin[1]), .first_gate_input_i(gate[0]),
		.second_gate_input_i(gate[1]), .ext_clock_pin_i(1'b0), .first_gate_polarity_i(pol[0]),
		.second_gate_polarity_i(pol[1]), .first_vector_ack_i(ack[0]), .second_vector_ack_i(ack[1]),
		.first_interrupt_enable_i(ien), .second_interrupt_enable_i(ien), .third_ext_tick_i(tick),
		.first_irq_o(irq[0]), .second_irq_o(irq[1]), .first_overflow_flag_o(flg[0]),
		.second_overflow_flag_o(flg[1]), .second_ovf_pulse_o(pulse), .third_low_tick_o(tlo),
		.third_high_tick_o(thi));

	dtp_pin_model #(.HOLD(2)) u_pins (.clk_sys_i(clk_sys_i), .fire_i(fire), .count_pin_o(cpin));

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (err_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run

	// Register write, strobe held across one rising edge
	task automatic wrr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys_i);
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(negedge clk_sys_i);
		wr = 1'b0;
	endtask : wrr

	// Register read; the expectation is noted for the monitor
	task automatic rdr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] mk);
		@(negedge clk_sys_i);
		addr = a;
		rd = 1'b1;
		exp_q.push_back(v);
		msk_q.push_back(mk);
		@(negedge clk_sys_i);
		rd = 1'b0;
	endtask : rdr

	task automatic pulse_pin(input int t, input int cnt);
		repeat (cnt) begin
			@(negedge clk_sys_i);
			fire[t] = 1'b1;
			@(negedge clk_sys_i);
			fire[t] = 1'b0;
			repeat (12) @(negedge clk_sys_i);
		end
	endtask : pulse_pin

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// Read data lands one cycle after the strobe; compare against oldest note
	always @(posedge clk_sys_i) rd_d <= rd;
	always @(negedge clk_sys_i) begin
		if (rd_d) begin
			m = msk_q.pop_front();
			check("read data", {8'h00, rdata & m}, {8'h00, exp_q.pop_front() & m});
		end
	end

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_sys_i) begin
		cyc++;
		if (pulse) pulses++;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end

	initial begin
		{reset_n_i, wr, rd, rd_d, tick, fire, ack, gate, addr, wdata} = '0;
		ien = 1'b1;
		pol = 2'b11;
		repeat (5) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		void'($urandom(32'h37236538));
		rdr(8'h8e, 8'h00, 8'hff);
		wrr(8'h8e, 8'hff);
		rdr(8'h8e, 8'h7b, 8'hff);
		rdr(8'h90, 8'h00, 8'hff);
		d = 8'($urandom);
		wrr(8'h8b, d);
		rdr(8'h8b, d, 8'hff);
		// Third timer tick routing for both select settings
		for (int s = 0; s < 2; s++) begin
			wrr(8'h8e, s ? 8'h60 : 8'h00);
			repeat (8) begin
				@(negedge clk_sys_i);
				tick = 1'($urandom);
				#1;
				check("low tick", {15'h0, tlo}, s ? 16'h1 : {15'h0, tick});
				check("high tick", {15'h0, thi}, s ? 16'h1 : {15'h0, tick});
			end
		end
		// Pin counting in every mode, both timers, exact edge counts
		for (int t = 0; t < 2; t++) begin
			for (int c = 0; c < 5; c++) begin
				wrr(8'h88, 8'h00);
				wrr(8'h89, {4'h0, nib[c]} << (4 * t));
				// Gate pin left inactive at a random level, so a set gate bit must block counting
				gate[t] = 1'($urandom);
				pol[t] = ~gate[t];
				wrr(8'h8a + 8'(t), lo[c]);
				wrr(8'h8c + 8'(t), hi[c]);
				wrr(8'h88, 8'h10 << (2 * t));
				p = pulses;
				pulse_pin(t, n[c]);
				e = (c == 3 || (t == 1 && c == 4)) ? 0 : 1;
				check("overflow pulses", 16'(pulses - p), 16'(t * e));
				check("overflow flag", {15'h0, flg[t]}, 16'(e));
				check("irq", {15'h0, irq[t]}, 16'(e));
				rdr(8'h8a + 8'(t), (t == 1 && c == 4) ? lo[c] : elo[c], c == 2 ? 8'h1f : 8'hff);
				rdr(8'h8c + 8'(t), ehi[c], 8'hff);
				@(negedge clk_sys_i);
				ack[t] = 1'b1;
				@(negedge clk_sys_i);
				ack[t] = 1'b0;
				#1;
				check("flag after ack", {15'h0, flg[t]}, 16'h0);
			end
		end
		// Prescaled timing over a fixed window
		for (int k = 0; k < 4; k++) begin
			wrr(8'h88, 8'h00);
			wrr(8'h89, 8'h01 << (4 * (k / 3)));
			wrr(8'h8e, 8'(k % 3 + k / 3));
			wrr(8'h8a + 8'(k / 3), 8'h00);
			wrr(8'h8c + 8'(k / 3), 8'h00);
			wrr(8'h88, 8'h10 << (2 * (k / 3)));
			repeat (480) @(negedge clk_sys_i);
			wrr(8'h88, 8'h00);
			rdr(8'h8a + 8'(k / 3), 8'h00, 8'h00);
			e = 482 / dv[k];
			check("prescaled count", {15'h0, (int'(rdata) >= e - 2) && (int'(rdata) <= e + 2)}, 16'h1);
		end
		complete_run();
	end
endmodule : dtp_timer_tb
